// ---- hw/cldc_map.svh ----
// Purpose: Constants for the continuous LED drive control block.
// Assumes: 50 MHz system clock.
// Notes: Counts are in clock cycles unless the name says otherwise.
`ifndef CLDC_MAP_SVH
`define CLDC_MAP_SVH
`define CLDC_REF_WIDTH 12
`define CLDC_PEAK_CURRENT_LIMIT_DAC_WIDTH 10
`define CLDC_SEL_WIDTH 4
`define CLDC_GAIN_WIDTH 4
`define CLDC_OFF_WIDTH 8
`define CLDC_OFF_RESET 8'h10
`define CLDC_SEL_NONE 4'h0
`define CLDC_CLK_MHZ 50
`endif

// ---- hw/cldc_pkg.sv ----
// Purpose: Types for the continuous LED drive control block.
// Assumes: Used through scoped names only.
// Notes: Blanking phase states are one-hot.
package cldc_pkg;
   typedef enum logic [3:0] {
      CLDC_IDLE = 4'b0001,
      CLDC_DISSIPATE = 4'b0010,
      CLDC_PRECHARGE = 4'b0100,
      CLDC_LIGHT = 4'b1000
   } cldc_phase_t;
endpackage

// ---- hw/cldc_link_if.sv ----
// Purpose: Signals between display controller and LED drive control.
// Assumes: Single clock domain.
// Notes: Controller drives segment framing; device drives nothing back.
`timescale 1ns/1ps
`include "cldc_map.svh"
interface cldc_link_if;
   logic [`CLDC_SEL_WIDTH-1:0] emitter_select_req;
   logic drive_request;
   logic low_resistance_shunt_req;
   logic dissipative_shunt_req;
   logic continuous_mode;
   logic [`CLDC_REF_WIDTH-1:0] light_reference;
   logic [`CLDC_PEAK_CURRENT_LIMIT_DAC_WIDTH-1:0] current_limit;
   logic [`CLDC_GAIN_WIDTH-1:0] amp_gain;
   logic [`CLDC_OFF_WIDTH-1:0] off_time;
   modport ctrl (
      output emitter_select_req, drive_request, low_resistance_shunt_req,
      output dissipative_shunt_req, continuous_mode, light_reference,
      output current_limit, amp_gain, off_time
   );
   modport drv (
      input emitter_select_req, drive_request, low_resistance_shunt_req,
      input dissipative_shunt_req, continuous_mode, light_reference,
      input current_limit, amp_gain, off_time
   );
endinterface

// ---- hw/cldc_ctrl_end.sv ----
// Purpose: Display controller end; frames each colour segment with blanking.
// Assumes: User supplies per-segment settings and durations in cycles.
// Notes: Time attenuation is the length of the light phase.
`timescale 1ns/1ps
`include "cldc_map.svh"
module cldc_ctrl_end #(
   parameter int DUR_WIDTH = 16
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Segment request from user
   input wire logic SEG_START,
   input wire logic [`CLDC_SEL_WIDTH-1:0] SEG_EMITTER,
   input wire logic [DUR_WIDTH-1:0] SEG_DISSIPATE_CYCLES,
   input wire logic [DUR_WIDTH-1:0] SEG_PRECHARGE_CYCLES,
   input wire logic [DUR_WIDTH-1:0] SEG_LIGHT_CYCLES,
   input wire logic [`CLDC_REF_WIDTH-1:0] SEG_REFERENCE,
   input wire logic [`CLDC_PEAK_CURRENT_LIMIT_DAC_WIDTH-1:0] SEG_BLANK_LIMIT,
   input wire logic [`CLDC_PEAK_CURRENT_LIMIT_DAC_WIDTH-1:0] SEG_LIGHT_LIMIT,
   input wire logic [`CLDC_GAIN_WIDTH-1:0] SEG_GAIN,
   input wire logic [`CLDC_OFF_WIDTH-1:0] SEG_OFF_TIME,
   input wire logic SEG_CONTINUOUS,
   // Status
   output logic SEG_BUSY,
   // Link
   cldc_link_if.ctrl LINK
);
   // Elaboration check: counters wider than 32 bits are not served
   if (DUR_WIDTH < 1 || DUR_WIDTH > 32) begin : g_bad_dur_width
      $error("DUR_WIDTH out of range");
   end

   cldc_pkg::cldc_phase_t phase_reg, phase_next;
   logic [DUR_WIDTH-1:0] cnt_reg, cnt_next;
   logic [DUR_WIDTH-1:0] pre_len_reg, light_len_reg;
   logic [`CLDC_SEL_WIDTH-1:0] emit_reg;
   logic [`CLDC_PEAK_CURRENT_LIMIT_DAC_WIDTH-1:0] blank_lim_reg, light_lim_reg;
   logic [`CLDC_REF_WIDTH-1:0] ref_reg;
   logic [`CLDC_GAIN_WIDTH-1:0] gain_reg;
   logic [`CLDC_OFF_WIDTH-1:0] off_reg;
   logic cont_reg;
   wire cnt_done = (cnt_reg <= DUR_WIDTH'(1));
   wire take = SEG_START && (phase_reg == cldc_pkg::CLDC_IDLE);

   // Phase sequencing: dissipate, pre-charge, light, back to idle
   always_comb begin
      phase_next = phase_reg;
      cnt_next = cnt_reg - DUR_WIDTH'(1);
      case (phase_reg)
         cldc_pkg::CLDC_IDLE: begin
            cnt_next = SEG_DISSIPATE_CYCLES;
            if (SEG_START) phase_next = cldc_pkg::CLDC_DISSIPATE;
         end
         cldc_pkg::CLDC_DISSIPATE: begin
            if (cnt_done) begin
               phase_next = cldc_pkg::CLDC_PRECHARGE;
               cnt_next = pre_len_reg;
            end
         end
         cldc_pkg::CLDC_PRECHARGE: begin
            if (cnt_done) begin
               phase_next = cldc_pkg::CLDC_LIGHT;
               cnt_next = light_len_reg;
            end
         end
         cldc_pkg::CLDC_LIGHT: begin
            if (cnt_done) phase_next = cldc_pkg::CLDC_IDLE;
         end
         default: phase_next = cldc_pkg::CLDC_IDLE;
      endcase
   end

   // Segment state; settings captured once per segment
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         phase_reg <= cldc_pkg::CLDC_IDLE;
         cnt_reg <= '0;
      end else begin
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         pre_len_reg <= '0;
         light_len_reg <= '0;
         emit_reg <= `CLDC_SEL_NONE;
         blank_lim_reg <= '0;
         light_lim_reg <= '0;
         ref_reg <= '0;
         gain_reg <= '0;
         off_reg <= `CLDC_OFF_RESET;
         cont_reg <= 1'b1;
      end else if (take) begin
         pre_len_reg <= SEG_PRECHARGE_CYCLES;
         light_len_reg <= SEG_LIGHT_CYCLES;
         emit_reg <= SEG_EMITTER;
         blank_lim_reg <= SEG_BLANK_LIMIT;
         light_lim_reg <= SEG_LIGHT_LIMIT;
         ref_reg <= SEG_REFERENCE;
         gain_reg <= SEG_GAIN;
         off_reg <= SEG_OFF_TIME;
         cont_reg <= SEG_CONTINUOUS;
      end
   end

   // Link enables, emitter select and current limit decoded from the phase; other settings pass straight through
   wire in_dis = (phase_reg == cldc_pkg::CLDC_DISSIPATE);
   wire in_pre = (phase_reg == cldc_pkg::CLDC_PRECHARGE);
   wire in_light = (phase_reg == cldc_pkg::CLDC_LIGHT);
   assign LINK.dissipative_shunt_req = in_dis;
   assign LINK.low_resistance_shunt_req = in_pre;
   assign LINK.drive_request = in_pre || in_light;
   assign LINK.emitter_select_req = in_light ? emit_reg : `CLDC_SEL_NONE;
   assign LINK.current_limit = in_light ? light_lim_reg : blank_lim_reg;
   assign LINK.light_reference = ref_reg;
   assign LINK.amp_gain = gain_reg;
   assign LINK.off_time = off_reg;
   assign LINK.continuous_mode = cont_reg;

   always_ff @(posedge CLK_SYS) begin
      if (RESET) SEG_BUSY <= 1'b0;
      else SEG_BUSY <= (phase_next != cldc_pkg::CLDC_IDLE);
   end
endmodule

// ---- hw/cldc_drive_end.sv ----
// Summary of operation
// - Light below reference asserts gate enable.
// - Light above reference drops gate enable quickly.
// - Regulate only while drive is enabled.
// - Current reaches emitter only when selected.
// - Controller supplies select, drive, shunt enables.
// - Controller varies enable lengths for time dimming.
// - Amplitude dimming via reference and gain.
// - Continuous mode drives capacitor select low.
// - Discontinuous mode drives capacitor select high.
// - Blanking is dissipation then pre-charge, dark.
// - Dissipative shunt on, emitters deselected first.
// - Pre-charge through shunt until current limit.
// - Release shunt, select emitter, toggle gate.
// - Controller loads limit from earlier measurements.
// - Threshold starts constant-off; comparator ignored meanwhile.
// - Drive stops at current limit or light.
//
// Purpose: Device end; hysteretic continuous-mode LED drive and blanking.
// Assumes: Comparator and limit inputs are asynchronous levels.
// Notes: Analog amplifier and DACs are outside; this end forwards their codes.
`timescale 1ns/1ps
`include "cldc_map.svh"
module cldc_drive_end #(
   parameter int OFF_WIDTH = `CLDC_OFF_WIDTH
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Link from controller
   cldc_link_if.drv LINK,
   // Analog comparator results, high when light below reference / current at limit
   input wire logic LIGHT_BELOW_REF,
   input wire logic CURRENT_AT_LIMIT,
   // Outputs to power stage
   output logic BUCK_GATE_ENABLE,
   output logic LOW_RESISTANCE_SHUNT_ENABLE,
   output logic DISSIPATIVE_SHUNT_ENABLE,
   output logic [`CLDC_SEL_WIDTH-1:0] EMITTER_SELECT,
   output logic BULK_CAP_SELECT,
   // Codes to analog converters
   output logic [`CLDC_REF_WIDTH-1:0] LIGHT_REFERENCE_DAC,
   output logic [`CLDC_PEAK_CURRENT_LIMIT_DAC_WIDTH-1:0] PEAK_CURRENT_LIMIT_DAC,
   output logic [`CLDC_GAIN_WIDTH-1:0] PHOTO_CURRENT_AMPLIFIER_GAIN,
   // Status
   output logic CONSTANT_OFF_ACTIVE
);
   // Elaboration check: the off-time code arrives at the link width
   if (OFF_WIDTH != `CLDC_OFF_WIDTH) begin : g_bad_off_width
      $error("OFF_WIDTH must match link width");
   end

   // Two-stage synchronisers; first stage feeds only the second
   logic [1:0] below_meta_reg, below_sync_reg;
   logic lim_meta_reg, lim_sync_reg;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         below_meta_reg <= 2'h0;
         below_sync_reg <= 2'h0;
         lim_meta_reg <= 1'b0;
         lim_sync_reg <= 1'b0;
      end else begin
         below_meta_reg <= {1'b0, LIGHT_BELOW_REF};
         below_sync_reg <= below_meta_reg;
         lim_meta_reg <= CURRENT_AT_LIMIT;
         lim_sync_reg <= lim_meta_reg;
      end
   end
   wire light_low = below_sync_reg[0];

   // Phase decode from controller enables
   wire dis_phase = LINK.dissipative_shunt_req;
   wire pre_phase = LINK.low_resistance_shunt_req && !dis_phase;
   wire light_phase = LINK.drive_request && !pre_phase && !dis_phase;
   wire cont = LINK.continuous_mode;

   // Constant-off timer
   logic [OFF_WIDTH-1:0] off_cnt_reg, off_cnt_next;
   logic gate_reg;
   wire off_running = (off_cnt_reg != '0);
   wire light_trip = light_phase && gate_reg && !light_low && !off_running;
   always_comb begin
      off_cnt_next = off_running ? off_cnt_reg - OFF_WIDTH'(1) : off_cnt_reg;
      if (!light_phase) off_cnt_next = '0;
      else if (light_trip) off_cnt_next = LINK.off_time;
   end

   // Gate enable: light regulation, pre-charge to limit, cut on limit first
   logic gate_next;
   always_comb begin
      gate_next = 1'b0;
      if (pre_phase) gate_next = !lim_sync_reg;
      else if (light_phase) begin
         if (lim_sync_reg || light_trip || off_running) gate_next = 1'b0;
         else gate_next = light_low;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         off_cnt_reg <= '0;
         gate_reg <= 1'b0;
      end else begin
         off_cnt_reg <= off_cnt_next;
         gate_reg <= gate_next;
      end
   end
   assign BUCK_GATE_ENABLE = gate_reg;

   // Registered outputs to the power stage and converters
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         LOW_RESISTANCE_SHUNT_ENABLE <= 1'b0;
         DISSIPATIVE_SHUNT_ENABLE <= 1'b0;
         EMITTER_SELECT <= `CLDC_SEL_NONE;
         BULK_CAP_SELECT <= 1'b0;
         LIGHT_REFERENCE_DAC <= '0;
         PEAK_CURRENT_LIMIT_DAC <= '0;
         PHOTO_CURRENT_AMPLIFIER_GAIN <= '0;
         CONSTANT_OFF_ACTIVE <= 1'b0;
      end else begin
         LOW_RESISTANCE_SHUNT_ENABLE <= pre_phase;
         DISSIPATIVE_SHUNT_ENABLE <= dis_phase;
         // Emitters stay dark in both blanking phases
         EMITTER_SELECT <= light_phase ? LINK.emitter_select_req : `CLDC_SEL_NONE;
         BULK_CAP_SELECT <= !cont;
         LIGHT_REFERENCE_DAC <= LINK.light_reference;
         PEAK_CURRENT_LIMIT_DAC <= LINK.current_limit;
         PHOTO_CURRENT_AMPLIFIER_GAIN <= LINK.amp_gain;
         CONSTANT_OFF_ACTIVE <= (off_cnt_next != '0);
      end
   end
   // Shunt release and the gate step share one edge, so no dark gap opens at handover
endmodule

// ---- test/cldc_link_properties.sv ----
// Purpose: Concurrent checks on the drive end, watched beside the link.
// Assumes: Every segment uses an off time of 5 cycles.
// Notes: Comparator pins pass two sync flops, so the gate-drop check spans three edges and the gate-rise check four.
`timescale 1ns/1ps
`include "cldc_map.svh"
module cldc_link_properties (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Link from the controller
   input wire logic [`CLDC_SEL_WIDTH-1:0] emitter_select_req,
   input wire logic drive_request,
   input wire logic low_resistance_shunt_req,
   input wire logic dissipative_shunt_req,
   input wire logic continuous_mode,
   // Drive end pins
   input wire logic LIGHT_BELOW_REF,
   input wire logic CURRENT_AT_LIMIT,
   input wire logic BUCK_GATE_ENABLE,
   input wire logic LOW_RESISTANCE_SHUNT_ENABLE,
   input wire logic DISSIPATIVE_SHUNT_ENABLE,
   input wire logic [`CLDC_SEL_WIDTH-1:0] EMITTER_SELECT,
   input wire logic BULK_CAP_SELECT,
   input wire logic CONSTANT_OFF_ACTIVE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   // Light phase on both sides of the link register, so pre-charge never counts
   wire light_ph = drive_request && !low_resistance_shunt_req && !LOW_RESISTANCE_SHUNT_ENABLE;
   // Steps of the handover and of the off timer
   sequence s_precharge_end;
      LOW_RESISTANCE_SHUNT_ENABLE ##1 !LOW_RESISTANCE_SHUNT_ENABLE;
   endsequence
   sequence s_off_run;
      CONSTANT_OFF_ACTIVE [*5] ##1 !CONSTANT_OFF_ACTIVE;
   endsequence
   a_cap_follows_mode: assert property (BULK_CAP_SELECT == !$past(continuous_mode))
      else $error("cap select wrong");
   a_select_follows: assert property (EMITTER_SELECT == $past(emitter_select_req))
      else $error("emitter select wrong");
   a_dark_blanking: assert property (DISSIPATIVE_SHUNT_ENABLE |-> !BUCK_GATE_ENABLE && EMITTER_SELECT == 4'h0)
      else $error("light during dissipation");
   a_idle_no_drive: assert property (!drive_request |=> !BUCK_GATE_ENABLE)
      else $error("gate on without drive");
   a_off_holds_gate: assert property (CONSTANT_OFF_ACTIVE |-> !BUCK_GATE_ENABLE)
      else $error("gate on during off time");
   a_off_time_length: assert property ($rose(CONSTANT_OFF_ACTIVE) |-> s_off_run)
      else $error("off time length wrong");
   a_gate_drops: assert property ((light_ph && !LIGHT_BELOW_REF) [*3] |=> !BUCK_GATE_ENABLE)
      else $error("gate stays on above reference");
   a_gate_rises: assert property ((light_ph && LIGHT_BELOW_REF && !CURRENT_AT_LIMIT && !CONSTANT_OFF_ACTIVE) [*4]
      |=> BUCK_GATE_ENABLE)
      else $error("gate off below reference");
   a_handover_select: assert property (s_precharge_end |-> EMITTER_SELECT != 4'h0)
      else $error("no emitter at handover");
endmodule

// ---- test/continuous_led_drive_control_tb.sv ----
// Purpose: Self-checking bench joining the controller end to the drive end.
// Assumes: Segments of 6, 6 and 40 cycles and an off time of 5 cycles.
// Notes: Comparator pins are synchronised, so the limit check waits three edges and the light check four after a change.
`timescale 1ns/1ps
`include "cldc_map.svh"
module continuous_led_drive_control_tb;
   logic CLK_SYS = 0, RESET = 1, SEG_START = 0, SEG_CONTINUOUS = 1, SEG_BUSY;
   logic LIGHT_BELOW_REF = 1, CURRENT_AT_LIMIT = 0;
   logic [3:0] SEG_EMITTER = 0, SEG_GAIN = 0, EMITTER_SELECT, PHOTO_CURRENT_AMPLIFIER_GAIN;
   logic [11:0] SEG_REFERENCE = 0, LIGHT_REFERENCE_DAC;
   logic [9:0] SEG_BLANK_LIMIT = 0, SEG_LIGHT_LIMIT = 0, PEAK_CURRENT_LIMIT_DAC;
   logic BUCK_GATE_ENABLE, LOW_RESISTANCE_SHUNT_ENABLE, DISSIPATIVE_SHUNT_ENABLE, BULK_CAP_SELECT, CONSTANT_OFF_ACTIVE;
   int fails = 0, n_compared = 0;
   // 50 MHz system clock
   always #10 CLK_SYS = ~CLK_SYS;
   // Both ends face each other across one link
   cldc_link_if link ();
   cldc_ctrl_end u_cldc_ctrl_end (.CLK_SYS, .RESET, .SEG_START, .SEG_EMITTER, .SEG_DISSIPATE_CYCLES(16'h0006),
      .SEG_PRECHARGE_CYCLES(16'h0006), .SEG_LIGHT_CYCLES(16'h0028), .SEG_REFERENCE, .SEG_BLANK_LIMIT,
      .SEG_LIGHT_LIMIT, .SEG_GAIN, .SEG_OFF_TIME(8'h05), .SEG_CONTINUOUS, .SEG_BUSY, .LINK(link));
   cldc_drive_end u_cldc_drive_end (.CLK_SYS, .RESET, .LINK(link), .LIGHT_BELOW_REF, .CURRENT_AT_LIMIT,
      .BUCK_GATE_ENABLE, .LOW_RESISTANCE_SHUNT_ENABLE, .DISSIPATIVE_SHUNT_ENABLE, .EMITTER_SELECT, .BULK_CAP_SELECT,
      .LIGHT_REFERENCE_DAC, .PEAK_CURRENT_LIMIT_DAC, .PHOTO_CURRENT_AMPLIFIER_GAIN, .CONSTANT_OFF_ACTIVE);
   cldc_link_properties u_cldc_link_properties (.CLK_SYS, .RESET, .emitter_select_req(link.emitter_select_req),
      .drive_request(link.drive_request), .low_resistance_shunt_req(link.low_resistance_shunt_req),
      .dissipative_shunt_req(link.dissipative_shunt_req), .continuous_mode(link.continuous_mode),
      .LIGHT_BELOW_REF, .CURRENT_AT_LIMIT, .BUCK_GATE_ENABLE, .LOW_RESISTANCE_SHUNT_ENABLE,
      .DISSIPATIVE_SHUNT_ENABLE, .EMITTER_SELECT, .BULK_CAP_SELECT, .CONSTANT_OFF_ACTIVE);
   // Shared helpers: settle past an edge, compare, close the run
   task automatic at(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Settings differ per emitter so a stale value shows up
   task automatic go(input logic [3:0] em, input logic cont);
      @(posedge CLK_SYS);
      SEG_START <= 1;
      SEG_EMITTER <= em;
      SEG_CONTINUOUS <= cont;
      SEG_REFERENCE <= {8'ha5, em};
      SEG_GAIN <= ~em;
      SEG_BLANK_LIMIT <= {6'h20, em};
      SEG_LIGHT_LIMIT <= {6'h31, em};
      @(posedge CLK_SYS) SEG_START <= 0;
   endtask
   task automatic do_reset();
      @(posedge CLK_SYS) RESET <= 1;
      repeat (2) @(posedge CLK_SYS);
      RESET <= 0;
      #1;
      chk({BUCK_GATE_ENABLE, LOW_RESISTANCE_SHUNT_ENABLE, DISSIPATIVE_SHUNT_ENABLE, EMITTER_SELECT, SEG_BUSY}, 0);
      chk(BULK_CAP_SELECT, 0);
      $display("reset done");
   endtask
   // One segment: dissipate, pre-charge to the limit, then regulate with an off-time trip
   task automatic seg(input logic [3:0] em, input logic cont);
      go(em, cont);
      at(3);
      chk({DISSIPATIVE_SHUNT_ENABLE, BUCK_GATE_ENABLE, EMITTER_SELECT}, 6'h20);
      chk(BULK_CAP_SELECT, !cont);
      at(5);
      chk({LOW_RESISTANCE_SHUNT_ENABLE, BUCK_GATE_ENABLE, EMITTER_SELECT}, 6'h30);
      chk(PEAK_CURRENT_LIMIT_DAC, {6'h20, em});
      @(posedge CLK_SYS) CURRENT_AT_LIMIT <= 1;
      at(3);
      chk(BUCK_GATE_ENABLE, 0);
      @(posedge CLK_SYS) CURRENT_AT_LIMIT <= 0;
      at(10);
      chk({BUCK_GATE_ENABLE, LOW_RESISTANCE_SHUNT_ENABLE, EMITTER_SELECT}, {2'b10, em});
      chk(PEAK_CURRENT_LIMIT_DAC, {6'h31, em});
      chk({LIGHT_REFERENCE_DAC, PHOTO_CURRENT_AMPLIFIER_GAIN}, {8'ha5, em, ~em});
      @(posedge CLK_SYS) LIGHT_BELOW_REF <= 0;
      at(4);
      chk({BUCK_GATE_ENABLE, CONSTANT_OFF_ACTIVE}, 2'b01);
      @(posedge CLK_SYS) LIGHT_BELOW_REF <= 1;
      at(1);
      chk({BUCK_GATE_ENABLE, CONSTANT_OFF_ACTIVE}, 2'b01);
      at(10);
      chk({BUCK_GATE_ENABLE, CONSTANT_OFF_ACTIVE}, 2'b10);
      for (int k = 0; k < 100 && SEG_BUSY !== 1'b0; k++) at(1);
      at(2);
      chk({BUCK_GATE_ENABLE, LOW_RESISTANCE_SHUNT_ENABLE, EMITTER_SELECT}, 0);
      $display("segment emitter %h mode %0d done", em, cont);
   endtask
   // Reset lands in the middle of a light phase
   task automatic t_abort();
      go(4'h2, 1);
      at(20);
      do_reset();
   endtask
   // Main sequence: every emitter, both modes, then recovery after an abort
   initial begin
      do_reset();
      seg(4'h1, 1);
      seg(4'h2, 1);
      seg(4'h4, 0);
      seg(4'h8, 1);
      t_abort();
      seg(4'h1, 1);
      close_out();
   end
   // Watchdog well beyond six segments of about sixty cycles each
   initial begin
      repeat (3000) @(posedge CLK_SYS);
      fails++;
      close_out();
   end
endmodule
